/* logic/tm8_pkg.sv */
package tm8_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_COUNTER = 2'h1;
  localparam logic [1:0] REG_COMPARE = 2'h2;
  localparam logic [1:0] REG_FLAGS = 2'h3;

  // Control register field positions
  localparam int FORCE_BIT = 7;
  localparam int WAVE_LOW_BIT = 6;
  localparam int ACTION_HI_BIT = 5;
  localparam int ACTION_LO_BIT = 4;
  localparam int WAVE_HIGH_BIT = 3;
  localparam int CLKSEL_HI_BIT = 2;

  // Flag register field positions
  localparam int CMP_FLAG_BIT = 0;
  localparam int OVF_FLAG_BIT = 1;

  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] COUNTER_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'h00;

  // Waveform modes {high, low}
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;

  // Compare output actions
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Clock sources
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_SYS = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler taps as log2 of the divisor
  localparam int TAP_LOG8 = 3;
  localparam int TAP_LOG64 = 6;
  localparam int TAP_LOG256 = 8;
  localparam int TAP_LOG1024 = 10;

  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [8:0] PC_PERIOD_TICKS = 9'h1FE;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } tm8_dir_type;

endpackage

/* logic/tm8_timer_ctrl.sv */
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Phase-correct period is 510 timer ticks.
// - Phase-correct extremes give constant low or high.
// - Leaving max, level at top equals up-match unless compare is max.
// - Missed up-match still applied at top.
// - All logic on system clock, tick enables.
// - Force strobe acts only in non-PWM modes.
// - Force applies match using written action bits.
// - Force sets no flag, never clears counter.
// - Force strobe bit always reads zero.
// - Mode bits 6 and 3 select mode.
// - Top source and compare update per mode.
// - Overflow at max, or bottom in phase-correct.
// - Nonzero action overrides pin; direction enables driver.
// - Non-PWM actions: off, toggle, clear, set.
// - Fast PWM: off, reserved, clear/set, set/clear.
// - Phase-correct: clear up set down, or inverse.
// - Compare equal top with high bit: top only.
// - Clock select: stop, sys, taps, external edges.
// - External pin counts even when driven out.
// - Dual slope, max held for one tick.
// - Clear-on-match returns to zero after match.
// - Counter write blocks next tick's match.
// - Compare flag set on match, cleared by ack/write.
module tm8_timer_ctrl
  import tm8_pkg::*;
#(
  parameter int PRESC_W = 10
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Interrupt vector acknowledges
  input wire logic compare_vec_ack_i,
  input wire logic overflow_vec_ack_i,
  // Pins
  input wire logic ext_count_input_i,
  input wire logic port_data_i,
  input wire logic port_dir_out_i,
  output logic compare_pin_o,
  output logic compare_pin_oe_b_o,
  // Status
  output logic compare_wave_out_o,
  output logic compare_flag_o,
  output logic overflow_flag_o
);

  logic [7:0] timer0_control_ff;
  logic [7:0] counter_value_ff;
  logic [7:0] nxt_counter_value;
  logic [7:0] compare_buf_ff;
  logic [7:0] compare_act_ff;
  logic [7:0] compare_used;
  tm8_dir_type dir_ff;
  tm8_dir_type nxt_dir;
  logic [PRESC_W-1:0] presc_ff;
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic ext_level_ff;
  logic ext_rise;
  logic ext_fall;
  logic block_ff;
  logic compare_flag_ff;
  logic overflow_flag_ff;
  logic wave_ff;
  logic nxt_wave;
  logic pin_ff;
  logic pin_oe_b_ff;
  logic [7:0] rdata_ff;
  logic timer_tick;
  logic match;
  logic at_top;
  logic ovf_evt;
  logic force_hit;
  logic is_pwm;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_flags;
  logic [1:0] waveform_mode_sel;
  logic [1:0] compare_output_action;
  logic [2:0] clock_source_sel;

  function automatic logic apply_action(input logic cur, input logic [1:0] act);
    case (act)
      ACT_TOGGLE: apply_action = ~cur;
      ACT_CLEAR: apply_action = 1'b0;
      ACT_SET: apply_action = 1'b1;
      default: apply_action = cur;
    endcase
  endfunction

  assign waveform_mode_sel = {timer0_control_ff[WAVE_HIGH_BIT],
                              timer0_control_ff[WAVE_LOW_BIT]};
  assign compare_output_action = timer0_control_ff[ACTION_HI_BIT:ACTION_LO_BIT];
  assign clock_source_sel = timer0_control_ff[CLKSEL_HI_BIT:0];
  assign is_pwm = timer0_control_ff[WAVE_LOW_BIT];

  assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_CONTROL);
  assign wr_cnt = reg_wr_i && (reg_addr_i == REG_COUNTER);
  assign wr_cmp = reg_wr_i && (reg_addr_i == REG_COMPARE);
  assign wr_flags = reg_wr_i && (reg_addr_i == REG_FLAGS);

  // Strobe qualified by the mode bit being written, not the old one
  assign force_hit = wr_ctrl && reg_wdata_i[FORCE_BIT] && !reg_wdata_i[WAVE_LOW_BIT];

  // Strobe bit is never stored
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer0_control_ff <= CONTROL_RST;
    end else if (wr_ctrl) begin
      timer0_control_ff <= {1'b0, reg_wdata_i[6:0]};
    end
  end

  // Free running prescaler
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + {{(PRESC_W-1){1'b0}}, 1'b1};
    end
  end

  // External count pin: three stages, a level counts once stages 2 and 3 agree
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      ext_level_ff <= 1'b0;
    end else begin
      sync1_ff <= ext_count_input_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) begin
        ext_level_ff <= sync3_ff;
      end
    end
  end

  assign ext_rise = (sync2_ff == sync3_ff) && sync3_ff && !ext_level_ff;
  assign ext_fall = (sync2_ff == sync3_ff) && !sync3_ff && ext_level_ff;

  // Tick is a clock enable only
  always_comb begin
    case (clock_source_sel)
      CS_STOP: timer_tick = 1'b0;
      CS_SYS: timer_tick = 1'b1;
      CS_DIV8: timer_tick = &presc_ff[TAP_LOG8-1:0];
      CS_DIV64: timer_tick = &presc_ff[TAP_LOG64-1:0];
      CS_DIV256: timer_tick = &presc_ff[TAP_LOG256-1:0];
      CS_DIV1024: timer_tick = &presc_ff[TAP_LOG1024-1:0];
      CS_EXT_FALL: timer_tick = ext_fall;
      CS_EXT_RISE: timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
  end

  // Compare register is buffered only in the PWM modes
  assign compare_used = is_pwm ? compare_act_ff : compare_buf_ff;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_buf_ff <= COMPARE_RST;
    end else if (wr_cmp) begin
      compare_buf_ff <= reg_wdata_i;
    end
  end

  // Top and bottom updates both land on the tick leaving max
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_act_ff <= COMPARE_RST;
    end else if (!is_pwm || at_top) begin
      compare_act_ff <= compare_buf_ff;
    end
  end

  assign at_top = timer_tick && is_pwm && (counter_value_ff == COUNT_MAX);
  assign match = timer_tick && !block_ff && (counter_value_ff == compare_used);

  always_comb begin
    nxt_counter_value = counter_value_ff + 8'h01;
    nxt_dir = DIR_UP;
    case (waveform_mode_sel)
      MODE_CLEAR: begin
        if (counter_value_ff == compare_buf_ff) begin
          nxt_counter_value = COUNT_BOTTOM;
        end
      end
      MODE_PHASE: begin
        case (dir_ff)
          DIR_UP: begin
            if (counter_value_ff == COUNT_MAX) begin
              nxt_counter_value = counter_value_ff - 8'h01;
              nxt_dir = DIR_DOWN;
            end else begin
              nxt_dir = (nxt_counter_value == COUNT_MAX) ? DIR_DOWN : DIR_UP;
            end
          end
          DIR_DOWN: begin
            if (counter_value_ff == COUNT_BOTTOM) begin
              nxt_dir = DIR_UP;
            end else begin
              nxt_counter_value = counter_value_ff - 8'h01;
              nxt_dir = (nxt_counter_value == COUNT_BOTTOM) ? DIR_UP : DIR_DOWN;
            end
          end
          default: nxt_dir = DIR_UP;
        endcase
      end
      default: nxt_dir = DIR_UP;
    endcase
  end

  // Software write wins over a tick in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counter_value_ff <= COUNTER_RST;
      dir_ff <= DIR_UP;
    end else if (wr_cnt) begin
      counter_value_ff <= reg_wdata_i;
    end else if (timer_tick) begin
      counter_value_ff <= nxt_counter_value;
      dir_ff <= nxt_dir;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      block_ff <= 1'b0;
    end else if (wr_cnt) begin
      block_ff <= 1'b1;
    end else if (timer_tick) begin
      block_ff <= 1'b0;
    end
  end

  assign ovf_evt = timer_tick && !wr_cnt && ((waveform_mode_sel == MODE_PHASE) ?
                   (counter_value_ff == COUNT_BOTTOM) : (counter_value_ff == COUNT_MAX));

  // Set beats clear; force never reaches the flag
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_flag_ff <= 1'b0;
      overflow_flag_ff <= 1'b0;
    end else begin
      if (match) begin
        compare_flag_ff <= 1'b1;
      end else if (compare_vec_ack_i || (wr_flags && reg_wdata_i[CMP_FLAG_BIT])) begin
        compare_flag_ff <= 1'b0;
      end
      if (ovf_evt) begin
        overflow_flag_ff <= 1'b1;
      end else if (overflow_vec_ack_i || (wr_flags && reg_wdata_i[OVF_FLAG_BIT])) begin
        overflow_flag_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_wave = wave_ff;
    if (force_hit) begin
      nxt_wave = apply_action(wave_ff, reg_wdata_i[ACTION_HI_BIT:ACTION_LO_BIT]);
    end else begin
      case (waveform_mode_sel)
        MODE_NORMAL, MODE_CLEAR: begin
          if (match) begin
            nxt_wave = apply_action(wave_ff, compare_output_action);
          end
        end
        MODE_FAST: begin
          // Code 1 is reserved and leaves the output alone
          if (compare_output_action[1]) begin
            if (match && (compare_used != COUNT_MAX)) begin
              nxt_wave = compare_output_action[0];
            end
            if (at_top) begin
              nxt_wave = ~compare_output_action[0];
            end
          end
        end
        MODE_PHASE: begin
          if (compare_output_action[1]) begin
            if (at_top) begin
              // Level at top is the up-match result unless compare sits at max
              if (compare_buf_ff == COUNT_MAX) begin
                nxt_wave = ~compare_output_action[0];
              end else begin
                nxt_wave = compare_output_action[0];
              end
            end else if (match && (compare_used != COUNT_MAX)) begin
              nxt_wave = (dir_ff == DIR_UP) ? compare_output_action[0] :
                         ~compare_output_action[0];
            end
          end
        end
        default: nxt_wave = wave_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wave_ff <= 1'b0;
    end else begin
      wave_ff <= nxt_wave;
    end
  end

  // Pin mux: port data unless an action is selected
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_ff <= 1'b0;
      pin_oe_b_ff <= 1'b1;
    end else begin
      pin_ff <= (compare_output_action != ACT_OFF) ? wave_ff : port_data_i;
      pin_oe_b_ff <= ~port_dir_out_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CONTROL: rdata_ff <= {1'b0, timer0_control_ff[6:0]};
        REG_COUNTER: rdata_ff <= counter_value_ff;
        REG_COMPARE: rdata_ff <= compare_buf_ff;
        REG_FLAGS: rdata_ff <= {6'h00, overflow_flag_ff, compare_flag_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign compare_wave_out_o = wave_ff;
  assign compare_pin_o = pin_ff;
  assign compare_pin_oe_b_o = pin_oe_b_ff;
  assign compare_flag_o = compare_flag_ff;
  assign overflow_flag_o = overflow_flag_ff;

  // Helper for the period check: ticks between bottoms, cleared on any disturbance
  logic [8:0] period_cnt_ff;
  logic period_clean_ff;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      period_cnt_ff <= 9'h000;
      period_clean_ff <= 1'b0;
    end else if (wr_cnt || wr_ctrl || (waveform_mode_sel != MODE_PHASE)) begin
      period_clean_ff <= 1'b0;
    end else if (ovf_evt) begin
      period_cnt_ff <= 9'h001;
      period_clean_ff <= 1'b1;
    end else if (timer_tick) begin
      period_cnt_ff <= period_cnt_ff + 9'h001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_phase_period: assert property (
    period_clean_ff && ovf_evt && !wr_ctrl |-> period_cnt_ff == PC_PERIOD_TICKS)
    else $error("phase-correct period not 510 ticks");

  a_phase_max_high: assert property (
    (waveform_mode_sel == MODE_PHASE) && (compare_output_action == ACT_CLEAR) && at_top &&
    (compare_buf_ff == COUNT_MAX) && !wr_ctrl |=> wave_ff)
    else $error("output not high at top with compare at max");

  a_phase_top_up: assert property (
    (waveform_mode_sel == MODE_PHASE) && (compare_output_action == ACT_SET) && at_top &&
    (compare_buf_ff != COUNT_MAX) && !wr_ctrl |=> wave_ff)
    else $error("top level not equal to up-match result");

  a_force_no_flag: assert property (
    force_hit && !match && !compare_flag_ff |=> !compare_flag_ff)
    else $error("forced compare set the flag");

  a_force_set: assert property (
    force_hit && (reg_wdata_i[ACTION_HI_BIT:ACTION_LO_BIT] == ACT_SET) |=> wave_ff)
    else $error("forced set did not raise output");

  a_force_read: assert property (
    $past(reg_rd_i) && ($past(reg_addr_i) == REG_CONTROL) |-> !reg_rdata_o[FORCE_BIT])
    else $error("force bit read back nonzero");

  a_phase_hold: assert property (
    (waveform_mode_sel == MODE_PHASE) && timer_tick && (counter_value_ff == COUNT_MAX) &&
    !wr_cnt && !wr_ctrl |=> counter_value_ff == (COUNT_MAX - 8'h01))
    else $error("phase-correct did not turn at max");

  a_clear_wrap: assert property (
    (waveform_mode_sel == MODE_CLEAR) && timer_tick && !wr_cnt && !wr_ctrl && !wr_cmp &&
    (counter_value_ff == compare_buf_ff) |=> counter_value_ff == COUNT_BOTTOM)
    else $error("clear-on-match did not return to zero");

  a_write_blocks: assert property (
    $past(wr_cnt) && !wr_cnt |-> !match)
    else $error("match not blocked after counter write");

  a_ovf_max: assert property (
    (waveform_mode_sel == MODE_NORMAL) && timer_tick && !wr_cnt &&
    (counter_value_ff == COUNT_MAX) |=> overflow_flag_ff)
    else $error("overflow flag not set at max");

  a_flag_clear: assert property (
    wr_flags && reg_wdata_i[CMP_FLAG_BIT] && !match ##1 !match |-> !compare_flag_ff)
    else $error("compare flag not cleared by write");

  a_stopped: assert property (
    (clock_source_sel == CS_STOP) && !wr_cnt |=> $stable(counter_value_ff))
    else $error("counter moved while stopped");

  a_fast_top: assert property (
    (waveform_mode_sel == MODE_FAST) && (compare_output_action == ACT_CLEAR) && at_top &&
    !wr_ctrl |=> wave_ff)
    else $error("fast PWM output not set at top");

  a_toggle: assert property (
    !is_pwm && (compare_output_action == ACT_TOGGLE) && match &&
    !force_hit |=> wave_ff != $past(wave_ff))
    else $error("toggle on match failed");

  a_pin_mux: assert property (
    (compare_output_action != ACT_OFF) && !wr_ctrl |=> compare_pin_o == $past(wave_ff))
    else $error("pin not driven by waveform");

  c_phase_period: cover property (period_clean_ff && ovf_evt);
  c_force: cover property (force_hit);
  c_ext_tick: cover property ((clock_source_sel == CS_EXT_RISE) && timer_tick);
  c_clear_match: cover property ((waveform_mode_sel == MODE_CLEAR) && match);

endmodule

/* test/tm8_pin_model.sv */
`timescale 1ns/1ps
module tm8_pin_model (
  // System side
  input wire logic core_clk_i,
  // Timer pins
  input wire logic compare_pin_i,
  input wire logic compare_pin_oe_b_i,
  output logic ext_count_o,
  output logic pad_o
);
  logic last_ff;

  initial begin
    ext_count_o = 1'b0;
    last_ff = 1'b0;
  end

  always @(posedge core_clk_i) begin
    if (!compare_pin_oe_b_i) begin
      last_ff <= compare_pin_i;
    end
  end

  // Released pad shows the inverse, so a stale level never passes
  assign pad_o = compare_pin_oe_b_i ? ~last_ff : compare_pin_i;

  // Each level lasts over one system cycle so the sampler sees it
  task automatic pulses(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge core_clk_i);
      ext_count_o <= 1'b1;
      repeat (half) @(posedge core_clk_i);
      ext_count_o <= 1'b0;
    end
  endtask
endmodule

/* test/timer8_waveform_control_tb.sv */
`timescale 1ns/1ps
module timer8_waveform_control_tb
  import tm8_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cmp_ack = 1'b0;
  logic ovf_ack = 1'b0;
  logic ext_cnt;
  logic port_data = 1'b0;
  logic port_dir = 1'b0;
  logic pin, pin_oe_b, wave, cmp_flag, ovf_flag, pad;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] rv;
  logic [15:0] h;

  always #5 core_clk_i = ~core_clk_i;

  tm8_timer_ctrl #(.PRESC_W(10)) dut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .compare_vec_ack_i(cmp_ack), .overflow_vec_ack_i(ovf_ack),
    .ext_count_input_i(ext_cnt), .port_data_i(port_data), .port_dir_out_i(port_dir),
    .compare_pin_o(pin), .compare_pin_oe_b_o(pin_oe_b), .compare_wave_out_o(wave),
    .compare_flag_o(cmp_flag), .overflow_flag_o(ovf_flag)
  );

  tm8_pin_model pin_m (
    .core_clk_i(core_clk_i), .compare_pin_i(pin), .compare_pin_oe_b_i(pin_oe_b),
    .ext_count_o(ext_cnt), .pad_o(pad)
  );

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [15:0] got, lo, hi, input string what);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %0d range %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic ack_pulse(input logic ovf);
    @(posedge core_clk_i);
    cmp_ack <= !ovf;
    ovf_ack <= ovf;
    @(posedge core_clk_i);
    cmp_ack <= 1'b0;
    ovf_ack <= 1'b0;
    @(negedge core_clk_i);
  endtask

  task automatic count_high(input int n, output logic [15:0] hc);
    hc = 16'h0000;
    repeat (n) begin
      @(negedge core_clk_i);
      hc = hc + {15'h0000, wave};
    end
  endtask

  task automatic next_rise(output logic [15:0] n);
    logic prev;
    prev = wave;
    n = 16'h0000;
    while (n < 16'h03E8) begin
      @(negedge core_clk_i);
      n++;
      if (wave === 1'b1 && prev === 1'b0) break;
      prev = wave;
    end
  endtask

  task automatic t_reset();
    rd(REG_CONTROL, rv);
    chk(rv, 8'h00, "control reset");
    rd(REG_COUNTER, rv);
    chk(rv, 8'h00, "counter reset");
    rd(REG_COMPARE, rv);
    chk(rv, 8'h00, "compare reset");
    rd(REG_FLAGS, rv);
    chk(rv, 8'h00, "flags reset");
    chk_bit(pin_oe_b, 1'b1, "pin released at reset");
  endtask

  task automatic t_force();
    wr(REG_COMPARE, 8'h05);
    wr(REG_COUNTER, 8'h05);
    wr(REG_FLAGS, 8'h03);
    port_dir <= 1'b1;
    wr(REG_CONTROL, 8'hB8);
    cyc(2);
    chk_bit(wave, 1'b1, "forced set");
    chk_bit(pin, 1'b1, "waveform owns pin");
    chk_bit(pad, 1'b1, "pad driven");
    chk_bit(pin_oe_b, 1'b0, "driver on");
    rd(REG_CONTROL, rv);
    chk(rv, 8'h38, "strobe reads zero");
    rd(REG_COUNTER, rv);
    chk(rv, 8'h05, "counter kept");
    chk_bit(cmp_flag, 1'b0, "no flag on force");
    wr(REG_CONTROL, 8'hA8);
    cyc(2);
    chk_bit(wave, 1'b0, "forced clear");
    wr(REG_CONTROL, 8'h98);
    cyc(2);
    chk_bit(wave, 1'b1, "forced toggle");
    wr(REG_CONTROL, 8'hE0);
    cyc(2);
    chk_bit(wave, 1'b1, "force ignored in pwm");
    wr(REG_CONTROL, 8'h00);
    cyc(2);
    chk_bit(pin, 1'b0, "port owns pin");
    port_dir <= 1'b0;
    cyc(2);
    chk_bit(pin_oe_b, 1'b1, "driver off");
  endtask

  task automatic t_ctc();
    wr(REG_COUNTER, 8'h00);
    wr(REG_COMPARE, 8'h02);
    wr(REG_FLAGS, 8'h03);
    wr(REG_CONTROL, 8'h19);
    cyc(6);
    count_high(60, h);
    chk_rng(h, 16'h001E, 16'h001E, "toggle every third tick");
    wr(REG_CONTROL, 8'h18);
    rd(REG_COUNTER, rv);
    chk_rng({8'h00, rv}, 16'h0000, 16'h0002, "count wraps at compare");
    chk_bit(cmp_flag, 1'b1, "match flag");
    ack_pulse(1'b0);
    chk_bit(cmp_flag, 1'b0, "vector clears match flag");
  endtask

  task automatic t_ovf();
    wr(REG_COUNTER, 8'hFD);
    wr(REG_FLAGS, 8'h03);
    wr(REG_CONTROL, 8'h01);
    cyc(8);
    wr(REG_CONTROL, 8'h00);
    chk_bit(ovf_flag, 1'b1, "overflow at max");
    wr(REG_FLAGS, 8'h02);
    cyc(1);
    chk_bit(ovf_flag, 1'b0, "write one clears");
  endtask

  task automatic t_presc();
    logic [2:0] cs [5];
    int dv [5];
    cs = '{CS_STOP, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
    dv = '{8, 8, 64, 256, 1024};
    for (int i = 0; i < 5; i++) begin
      wr(REG_CONTROL, {5'h00, cs[i]});
      wr(REG_COUNTER, 8'h00);
      cyc(4 * dv[i]);
      rd(REG_COUNTER, rv);
      chk_rng({8'h00, rv}, (i == 0) ? 16'h0000 : 16'h0003,
              (i == 0) ? 16'h0000 : 16'h0005, "ticks per window");
    end
    wr(REG_CONTROL, 8'h00);
  endtask

  task automatic t_ext();
    port_dir <= 1'b1;
    wr(REG_CONTROL, {5'h00, CS_EXT_RISE});
    wr(REG_COUNTER, 8'h00);
    pin_m.pulses(5, 2);
    cyc(6);
    rd(REG_COUNTER, rv);
    chk(rv, 8'h05, "rising edges counted");
    wr(REG_CONTROL, {5'h00, CS_EXT_FALL});
    wr(REG_COUNTER, 8'h00);
    pin_m.pulses(3, 5);
    cyc(6);
    rd(REG_COUNTER, rv);
    chk(rv, 8'h03, "falling edges counted");
    wr(REG_CONTROL, 8'h00);
    port_dir <= 1'b0;
  endtask

  task automatic t_pwm(input logic [7:0] ctrl, cmp, input int per, input logic [15:0] lo, hi);
    wr(REG_COMPARE, cmp);
    wr(REG_CONTROL, ctrl);
    cyc(2 * per);
    count_high(per, h);
    chk_rng(h, lo, hi, "high ticks per period");
  endtask

  task automatic t_period();
    wr(REG_COMPARE, 8'h80);
    wr(REG_CONTROL, 8'h61);
    cyc(1100);
    next_rise(h);
    next_rise(h);
    chk_rng(h, 16'h01FE, 16'h01FE, "dual slope period");
    wr(REG_FLAGS, 8'h03);
    cyc(520);
    chk_bit(ovf_flag, 1'b1, "overflow at bottom");
    wr(REG_CONTROL, 8'h00);
    ack_pulse(1'b1);
    chk_bit(ovf_flag, 1'b0, "vector clears overflow");
  endtask

  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_force();
    t_ctc();
    t_ovf();
    t_presc();
    t_ext();
    t_pwm(8'h61, 8'h00, 510, 16'h0000, 16'h0000);
    t_pwm(8'h61, 8'hFF, 510, 16'h01FE, 16'h01FE);
    t_pwm(8'h71, 8'h00, 510, 16'h01FE, 16'h01FE);
    t_pwm(8'h61, 8'h80, 510, 16'h00FE, 16'h0102);
    t_pwm(8'h69, 8'h40, 256, 16'h003F, 16'h0043);
    t_pwm(8'h79, 8'h40, 256, 16'h00BD, 16'h00C1);
    t_pwm(8'h69, 8'hFF, 256, 16'h0100, 16'h0100);
    t_period();
    results();
  end

  initial begin
    repeat (40000) @(posedge core_clk_i);
    fail_count++;
    results();
  end
endmodule
